// ### src/ccpc_top.sv
// cpu clock selection, auto slowdown, dma clock, pll control and clock pin mux
// assumes byte i/o cycles to the index/data port pair and a power manager mode input
`timescale 1ns/100ps
// Notes on behaviour
// [RL1] registers 80h-83h via ports 22h/23h
// [RL2] three-bit read-only present cpu speed
// [RL3] code 110 means multiplied, see bit0
// [RL4] writes to present speed ignored
// [RL5] low mode rate from low select
// [RL6] high mode rate from high select
// [RL7] hyper mode doubles or triples clock
// [RL8] override allows slowdown under external power
// [RL9] slowdown alternates in highest allowed mode
// [RL10] slow period 0.25 to 2 seconds
// [RL11] slow rate high or low mode
// [RL12] fast period 4 to 32 seconds
// [RL13] fast rate hyper or high mode
// [RL14] dma clock select, capped by cpu
// [RL15] standby may switch high pll off
// [RL16] live 32 kHz level, writes ignored
// [RL17] system pll restart delay 32-4 ms
// [RL18] suspend keeps or stops system plls
// [RL19] clock pin source select mux
module ccpc_top #(
  parameter longint SLOW_UNIT = ccpc_pkg::SLOW_CYCLES,
  parameter longint FAST_UNIT = ccpc_pkg::FAST_CYCLES,
  parameter longint PLL_UNIT  = ccpc_pkg::PLL_CYCLES
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // i/o bus
  input  wire logic [15:0] io_addr,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  // power manager
  input  wire logic [2:0]  power_manager_mode,
  input  wire logic        hyper_enabled,
  input  wire logic        external_power_input,
  input  wire logic        slow_oscillator,
  // clock generator controls
  output logic      [3:0]  processor_clock_rate,
  output logic      [3:0]  dma_clock_rate,
  output logic             high_pll_on,
  output logic             system_pll_on,
  output logic             system_pll_ready,
  output logic      [3:0]  clock_pin_select,
  output logic             clock_pin_oe
);
  logic [7:0] index_q;
  logic [4:0] speed_q;
  logic [5:0] slow_q;
  logic [7:0] clkctl_q;
  logic [3:0] pinsel_q;
  logic       data_wr;
  logic       data_rd;
  logic [3:0] rate_d;
  logic [3:0] low_rate;
  logic [3:0] high_rate;
  logic [3:0] hyper_rate;
  logic [2:0] pres_d;
  logic       highest;
  logic       sd_allow;
  ccpc_pkg::ccpc_sd_t  sd_q;
  ccpc_pkg::ccpc_pll_t pl_q;
  logic [31:0] sd_cnt_q;
  logic [31:0] pll_cnt_q;
  logic        pll_want;
  logic        pll_want_q;
  logic [31:0] fast_last;
  logic [31:0] slow_last;
  logic [31:0] pll_last;
  logic        fast_done;
  logic        slow_done;
  logic        high_want;

  // [RL1] data port decode
  assign data_wr = io_wr && (io_addr == ccpc_pkg::DATA_PORT);
  assign data_rd = io_rd && (io_addr == ccpc_pkg::DATA_PORT);

  // index latch
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      index_q <= 8'h00;
    end else if (io_wr && io_addr == ccpc_pkg::IDX_PORT) begin
      index_q <= io_wdata;
    end
  end

  // [RL4] writable fields only; present speed not stored
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      speed_q  <= ccpc_pkg::SPEED_RST;
      slow_q   <= ccpc_pkg::SLOW_RST;
      clkctl_q <= ccpc_pkg::CLKCTL_RST;
      pinsel_q <= ccpc_pkg::PINSEL_RST;
    end else if (data_wr) begin
      case (index_q)
        ccpc_pkg::IDX_SPEED:    speed_q  <= io_wdata[4:0];
        ccpc_pkg::IDX_SLOWDOWN: slow_q   <= io_wdata[5:0];
        // [RL16] sample bit is not writable
        ccpc_pkg::IDX_CLKCTL:   clkctl_q <= {io_wdata[7:4], 1'b0, io_wdata[2:0]};
        ccpc_pkg::IDX_PINSEL:   pinsel_q <= io_wdata[3:0];
        default: ;
      endcase
    end
  end

  // [RL5] low mode rates
  always_comb begin
    case (speed_q[4:3])
      2'h0:    low_rate = ccpc_pkg::CR_8M29;
      2'h1:    low_rate = ccpc_pkg::CR_4M15;
      2'h2:    low_rate = ccpc_pkg::CR_2M07;
      default: low_rate = ccpc_pkg::CR_1M04;
    endcase
  end

  // [RL6] high mode rates; reserved code falls back to 8.29
  always_comb begin
    case (speed_q[2:1])
      2'h1:    high_rate = ccpc_pkg::CR_16M59;
      2'h2:    high_rate = ccpc_pkg::CR_33M18;
      default: high_rate = ccpc_pkg::CR_8M29;
    endcase
  end

  // [RL7] hyper doubles or triples
  assign hyper_rate = speed_q[0] ? ccpc_pkg::CR_99M : ccpc_pkg::CR_66M;

  // [RL9] highest allowed mode depends on hyper availability
  assign highest = hyper_enabled ? (power_manager_mode == ccpc_pkg::PM_HYPER)
                                 : (power_manager_mode == ccpc_pkg::PM_HIGH);
  // [RL8] external power blocks slowdown unless overridden
  assign sd_allow = slow_q[4] && highest && (!external_power_input || slow_q[5]);

  // [RL10] [RL12] last count of each phase; the unit doubles per code step
  assign fast_last = 32'((FAST_UNIT << slow_q[1:0]) - 1);
  assign slow_last = 32'((SLOW_UNIT << slow_q[3:2]) - 1);
  // compare with >= so a shorter code written mid-phase ends it at once
  assign fast_done = (sd_cnt_q >= fast_last);
  assign slow_done = (sd_cnt_q >= slow_last);

  // slowdown sequencer; counter is wide enough for 32 s at 25 MHz
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sd_q     <= ccpc_pkg::SD_IDLE;
      sd_cnt_q <= 32'h0000_0000;
    end else begin
      case (sd_q)
        ccpc_pkg::SD_IDLE: begin
          sd_cnt_q <= 32'h0000_0000;
          if (sd_allow) begin
            sd_q <= ccpc_pkg::SD_FAST;
          end
        end
        ccpc_pkg::SD_FAST: begin
          // [RL12] fast hold 4 s shifted by code
          if (!sd_allow) begin
            sd_q <= ccpc_pkg::SD_IDLE;
          end else if (fast_done) begin
            sd_q     <= ccpc_pkg::SD_SLOW;
            sd_cnt_q <= 32'h0000_0000;
          end else begin
            sd_cnt_q <= sd_cnt_q + 32'h0000_0001;
          end
        end
        ccpc_pkg::SD_SLOW: begin
          // [RL10] slow hold 0.25 s shifted by code
          if (!sd_allow) begin
            sd_q <= ccpc_pkg::SD_IDLE;
          end else if (slow_done) begin
            sd_q     <= ccpc_pkg::SD_FAST;
            sd_cnt_q <= 32'h0000_0000;
          end else begin
            sd_cnt_q <= sd_cnt_q + 32'h0000_0001;
          end
        end
        default: begin
          sd_q     <= ccpc_pkg::SD_IDLE;
          sd_cnt_q <= 32'h0000_0000;
        end
      endcase
    end
  end

  // rate for the current mode and slowdown phase
  always_comb begin
    case (power_manager_mode)
      ccpc_pkg::PM_LOW:   rate_d = low_rate;
      ccpc_pkg::PM_HIGH:  rate_d = high_rate;
      ccpc_pkg::PM_HYPER: rate_d = hyper_rate;
      default:            rate_d = ccpc_pkg::CR_STOP;
    endcase
    // sequencer lags a mode change by one edge, so gate on the live permission
    if (sd_allow && sd_q == ccpc_pkg::SD_SLOW) begin
      // [RL11] slow rate one step below top
      rate_d = hyper_enabled ? high_rate : low_rate;
    end else if (sd_allow && sd_q == ccpc_pkg::SD_FAST) begin
      // [RL13] fast rate is the top mode
      rate_d = hyper_enabled ? hyper_rate : high_rate;
    end
  end

  // [RL2] [RL3] present speed code from running rate
  always_comb begin
    case (processor_clock_rate)
      ccpc_pkg::CR_1M04:  pres_d = ccpc_pkg::SPD_1M;
      ccpc_pkg::CR_2M07:  pres_d = ccpc_pkg::SPD_2M;
      ccpc_pkg::CR_4M15:  pres_d = ccpc_pkg::SPD_4M;
      ccpc_pkg::CR_8M29:  pres_d = ccpc_pkg::SPD_8M;
      ccpc_pkg::CR_16M59: pres_d = ccpc_pkg::SPD_16M;
      ccpc_pkg::CR_33M18: pres_d = ccpc_pkg::SPD_33M;
      ccpc_pkg::CR_66M:   pres_d = ccpc_pkg::SPD_MULT;
      ccpc_pkg::CR_99M:   pres_d = ccpc_pkg::SPD_MULT;
      default:            pres_d = ccpc_pkg::SPD_1M;
    endcase
  end

  // registered clock outputs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      processor_clock_rate <= ccpc_pkg::CR_8M29;
      dma_clock_rate       <= ccpc_pkg::CR_4M15;
      clock_pin_select     <= ccpc_pkg::PINSEL_RST;
      clock_pin_oe         <= 1'b0;
    end else begin
      processor_clock_rate <= rate_d;
      // [RL14] dma rate, never faster than a running cpu; stays at its cap while the cpu is stopped
      case (clkctl_q[ccpc_pkg::DMA_LSB +: 2])
        2'h0:    dma_clock_rate <= ccpc_pkg::CR_STOP;
        2'h1:    dma_clock_rate <= (rate_d < ccpc_pkg::CR_4M15) ? rate_d : ccpc_pkg::CR_4M15;
        2'h2:    dma_clock_rate <= (rate_d < ccpc_pkg::CR_8M29) ? rate_d : ccpc_pkg::CR_8M29;
        default: dma_clock_rate <= (rate_d < ccpc_pkg::CR_16M59) ? rate_d : ccpc_pkg::CR_16M59;
      endcase
      // [RL19] pin source select, top bit gives dc
      clock_pin_select <= pinsel_q;
      clock_pin_oe     <= !pinsel_q[3] && (pinsel_q != 4'h1);
    end
  end

  // [RL15] [RL18] pll enables by power mode
  assign pll_want = !((power_manager_mode == ccpc_pkg::PM_SUSPEND) && !clkctl_q[ccpc_pkg::SUSP_BIT]);
  // [RL15] high pll off in standby when asked, and with the system plls in suspend
  assign high_want = !((power_manager_mode == ccpc_pkg::PM_STANDBY) && clkctl_q[ccpc_pkg::STBY_BIT]) && pll_want;

  // [RL17] last count of the restart wait; the unit halves per code step
  assign pll_last = 32'((PLL_UNIT >> clkctl_q[ccpc_pkg::DLY_LSB +: 2]) - 1);

  // [RL17] restart delay; cpu pll not affected
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pl_q             <= ccpc_pkg::PL_RUN;
      pll_cnt_q        <= 32'h0000_0000;
      pll_want_q       <= 1'b1;
      system_pll_on    <= 1'b1;
      system_pll_ready <= 1'b1;
      high_pll_on      <= 1'b1;
    end else begin
      pll_want_q    <= pll_want;
      system_pll_on <= pll_want;
      high_pll_on   <= high_want;
      case (pl_q)
        ccpc_pkg::PL_RUN: begin
          system_pll_ready <= pll_want;
          if (pll_want && !pll_want_q) begin
            pl_q             <= ccpc_pkg::PL_WAIT;
            pll_cnt_q        <= 32'h0000_0000;
            system_pll_ready <= 1'b0;
          end
        end
        ccpc_pkg::PL_WAIT: begin
          if (!pll_want) begin
            pl_q <= ccpc_pkg::PL_RUN;
          end else if (pll_cnt_q >= pll_last) begin
            pl_q             <= ccpc_pkg::PL_RUN;
            system_pll_ready <= 1'b1;
          end else begin
            pll_cnt_q <= pll_cnt_q + 32'h0000_0001;
          end
        end
        default: pl_q <= ccpc_pkg::PL_RUN;
      endcase
    end
  end

  // read data, registered one cycle after the read strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      io_rdata <= 8'h00;
    end else if (data_rd) begin
      case (index_q)
        ccpc_pkg::IDX_SPEED:    io_rdata <= {pres_d, speed_q};
        ccpc_pkg::IDX_SLOWDOWN: io_rdata <= {2'h0, slow_q};
        // [RL16] live oscillator level
        ccpc_pkg::IDX_CLKCTL:   io_rdata <= {clkctl_q[7:4], slow_oscillator, clkctl_q[2:0]};
        ccpc_pkg::IDX_PINSEL:   io_rdata <= {4'h0, pinsel_q};
        default:                io_rdata <= 8'hFF;
      endcase
    end else if (io_rd && io_addr == ccpc_pkg::IDX_PORT) begin
      io_rdata <= index_q;
    end
  end
endmodule

// ### src/ccpc_pkg.sv
// constants for the cpu clock and power control block
// assumes a 25 MHz core clock and byte-wide indexed config port access
package ccpc_pkg;
  // indexed config port pair and register indices
  localparam logic [15:0] IDX_PORT     = 16'h0022;
  localparam logic [15:0] DATA_PORT    = 16'h0023;
  localparam logic [7:0]  IDX_SPEED    = 8'h80;
  localparam logic [7:0]  IDX_SLOWDOWN = 8'h81;
  localparam logic [7:0]  IDX_CLKCTL   = 8'h82;
  localparam logic [7:0]  IDX_PINSEL   = 8'h83;
  // reset values
  localparam logic [4:0]  SPEED_RST    = 5'h00;
  localparam logic [5:0]  SLOW_RST     = 6'h00;
  localparam logic [7:0]  CLKCTL_RST   = 8'h21;
  localparam logic [3:0]  PINSEL_RST   = 4'h8;
  // field positions in the clock control register
  localparam int DMA_LSB   = 5;
  localparam int STBY_BIT  = 4;
  localparam int OSC_BIT   = 3;
  localparam int DLY_LSB   = 1;
  localparam int SUSP_BIT  = 0;
  // present speed codes
  localparam logic [2:0]  SPD_1M   = 3'h0;
  localparam logic [2:0]  SPD_2M   = 3'h1;
  localparam logic [2:0]  SPD_4M   = 3'h2;
  localparam logic [2:0]  SPD_8M   = 3'h3;
  localparam logic [2:0]  SPD_16M  = 3'h4;
  localparam logic [2:0]  SPD_33M  = 3'h5;
  localparam logic [2:0]  SPD_MULT = 3'h6;
  // power manager modes
  typedef enum logic [2:0] {
    PM_LOW     = 3'h0,
    PM_HIGH    = 3'h1,
    PM_HYPER   = 3'h2,
    PM_STANDBY = 3'h3,
    PM_SUSPEND = 3'h4
  } ccpc_mode_t;
  // clock rate selector presented to the clock generator
  typedef enum logic [3:0] {
    CR_1M04  = 4'h0,
    CR_2M07  = 4'h1,
    CR_4M15  = 4'h2,
    CR_8M29  = 4'h3,
    CR_16M59 = 4'h4,
    CR_33M18 = 4'h5,
    CR_66M   = 4'h6,
    CR_99M   = 4'h7,
    CR_STOP  = 4'hF
  } ccpc_rate_t;
  // timing
  localparam longint CLK_HZ       = 25000000;
  localparam longint SLOW_BASE_MS = 250;
  localparam longint FAST_BASE_S  = 4;
  localparam longint PLL_MAX_MS   = 32;
  localparam longint MS_CYCLES    = CLK_HZ / 1000;
  localparam longint SLOW_CYCLES  = SLOW_BASE_MS * MS_CYCLES;
  localparam longint FAST_CYCLES  = FAST_BASE_S * CLK_HZ;
  localparam longint PLL_CYCLES   = PLL_MAX_MS * MS_CYCLES;
  // slowdown one-hot state
  typedef enum logic [2:0] {
    SD_IDLE = 3'b001,
    SD_FAST = 3'b010,
    SD_SLOW = 3'b100
  } ccpc_sd_t;
  typedef enum logic [1:0] {
    PL_RUN  = 2'b01,
    PL_WAIT = 2'b10
  } ccpc_pll_t;
endpackage

// ### tb/ccpc_monitor.sv
// port assertions for the cpu clock and power control block
// bound onto ccpc_top, sees only its ports, one clock domain
`timescale 1ns/100ps
module ccpc_monitor #(
  parameter longint PLL_UNIT = 32
) (
  // clock and reset
  input wire logic       clk,
  input wire logic       nrst,
  // bus and power manager
  input wire logic       io_rd,
  input wire logic [7:0] io_rdata,
  input wire logic [2:0] power_manager_mode,
  // clock controls
  input wire logic [3:0] processor_clock_rate,
  input wire logic [3:0] dma_clock_rate,
  input wire logic       high_pll_on,
  input wire logic       system_pll_on,
  input wire logic       system_pll_ready,
  input wire logic [3:0] clock_pin_select,
  input wire logic       clock_pin_oe
);
  // longest restart wait plus slack for the mode pipeline
  localparam int PLL_MAX = PLL_UNIT + 8;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // restart steps: ready drops, then stays low a while
  sequence s_restart;
    $fell(system_pll_ready);
  endsequence
  sequence s_min_wait;
    !system_pll_ready [*3];
  endsequence
  chk_pll_min_wait: assert property (s_restart |-> s_min_wait)
    else $error("pll ready came back too early");
  chk_pll_max_wait: assert property (s_restart |-> ##[1:PLL_MAX] system_pll_ready)
    else $error("pll ready did not come back");
  chk_susp_stop: assert property (!system_pll_on |-> $past(power_manager_mode) == 3'h4
    || $past(power_manager_mode, 2) == 3'h4)
    else $error("system pll stopped outside suspend");
  chk_stby_pll: assert property (!high_pll_on |-> $past(power_manager_mode) >= 3'h3
    || $past(power_manager_mode, 2) >= 3'h3)
    else $error("high pll off outside standby or suspend");
  chk_rate_code: assert property (processor_clock_rate <= 4'h7 || processor_clock_rate == 4'hF)
    else $error("cpu rate code out of range");
  chk_low_cap: assert property (power_manager_mode == 3'h0 && $past(power_manager_mode) == 3'h0
    && $past(power_manager_mode, 2) == 3'h0 |-> processor_clock_rate <= 4'h3)
    else $error("low mode rate above 8.29");
  chk_dma_cap: assert property ($stable(processor_clock_rate) && $past(processor_clock_rate)
    == $past(processor_clock_rate, 2) && dma_clock_rate != 4'hF && processor_clock_rate != 4'hF
    |-> dma_clock_rate <= processor_clock_rate && dma_clock_rate <= 4'h4)
    else $error("dma rate above cap");
  chk_pin_oe: assert property (clock_pin_oe == (!clock_pin_select[3] && clock_pin_select != 4'h1))
    else $error("clock pin enable wrong for select");
  chk_rdata_hold: assert property (!$past(io_rd) && !$past(io_rd, 2) |-> $stable(io_rdata))
    else $error("read data changed without a read");
endmodule

// ### tb/testbench.sv
// self-checking bench for the cpu clock and power control block
// drives the index/data port pair and the power manager inputs itself
`timescale 1ns/100ps
module testbench;
  // design connections
  logic        clk      = 1'b0;
  logic        nrst     = 1'b0;
  logic [15:0] io_addr  = 16'h0000;
  logic        io_wr    = 1'b0;
  logic        io_rd    = 1'b0;
  logic [7:0]  io_wdata = 8'h00;
  logic [2:0]  pm_mode  = 3'h0;
  logic        hyp_en   = 1'b0;
  logic        ext_pwr  = 1'b0;
  logic        osc      = 1'b0;
  logic [7:0]  io_rdata;
  logic [3:0]  cpu_rate;
  logic [3:0]  dma_rate;
  logic [3:0]  pin_sel;
  logic        hi_pll;
  logic        sys_pll;
  logic        sys_rdy;
  logic        pin_oe;
  logic [7:0]  rv;
  int          n_mismatch = 0;
  int          checks     = 0;
  int          n;
  always #20 clk = ~clk;
  // short counts keep slowdown and pll waits brief
  ccpc_top #(.SLOW_UNIT(20), .FAST_UNIT(80), .PLL_UNIT(32)) i_ccpc_top (
    .clk(clk), .nrst(nrst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .power_manager_mode(pm_mode), .hyper_enabled(hyp_en),
    .external_power_input(ext_pwr), .slow_oscillator(osc), .processor_clock_rate(cpu_rate),
    .dma_clock_rate(dma_rate), .high_pll_on(hi_pll), .system_pll_on(sys_pll),
    .system_pll_ready(sys_rdy), .clock_pin_select(pin_sel), .clock_pin_oe(pin_oe));
  // edges, then the fixed drive skew
  task tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // index cycle then data cycle; outputs settle two edges later
  task wr(input logic [7:0] idx, input logic [7:0] d);
    io_addr = ccpc_pkg::IDX_PORT;
    io_wdata = idx;
    io_wr = 1'b1;
    tick(1);
    io_addr = ccpc_pkg::DATA_PORT;
    io_wdata = d;
    tick(1);
    io_wr = 1'b0;
    tick(3);
  endtask
  task rd(input logic [7:0] idx);
    io_addr = ccpc_pkg::IDX_PORT;
    io_wdata = idx;
    io_wr = 1'b1;
    tick(1);
    io_wr = 1'b0;
    io_rd = 1'b1;
    io_addr = ccpc_pkg::DATA_PORT;
    tick(1);
    io_rd = 1'b0;
    tick(1);
    rv = io_rdata;
  endtask
  // cycles spent at one rate, bounded
  task dur(input logic [3:0] r);
    n = 0;
    while (cpu_rate === r && n < 1000) begin
      tick(1);
      n++;
    end
  endtask
  task near(input int exp);
    cmp(8'(n >= exp - 4 && n <= exp + 4), 8'h01);
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // hang guard, far beyond the under one thousand cycles needed
  initial begin
    #2000000;
    n_mismatch++;
    stop_test();
  end
  initial begin
    tick(12);
    nrst = 1'b1;
    rd(8'h80);
    cmp(rv, 8'h60);
    rd(8'h81);
    cmp(rv, 8'h00);
    rd(8'h82);
    cmp(rv, ccpc_pkg::CLKCTL_RST);
    rd(8'h83);
    cmp(rv, 8'h08);
    rd(8'h84);
    cmp(rv, 8'hFF);
    $display("test registers done");
    // low mode; writes to the present field must not stick
    for (int i = 0; i < 4; i++) begin
      wr(8'h80, 8'(8'hE0 | (i << 3)));
      rd(8'h80);
      cmp({4'h0, cpu_rate}, 8'(3 - i));
      cmp(rv, 8'(((3 - i) << 5) | (i << 3)));
    end
    pm_mode = 3'h1;
    for (int i = 0; i < 3; i++) begin
      wr(8'h80, 8'(i << 1));
      rd(8'h80);
      cmp({4'h0, cpu_rate}, 8'(3 + i));
      cmp(rv, 8'(((3 + i) << 5) | (i << 1)));
    end
    pm_mode = 3'h2;
    hyp_en = 1'b1;
    for (int i = 0; i < 2; i++) begin
      wr(8'h80, 8'(i));
      rd(8'h80);
      cmp({4'h0, cpu_rate}, 8'(6 + i));
      cmp(rv, 8'(8'hC0 | i));
    end
    // dma codes under the fastest cpu clock, then capped by a slow one
    for (int d = 0; d < 4; d++) begin
      wr(8'h82, 8'((d << 5) | 1));
      cmp({4'h0, dma_rate}, d == 0 ? 8'h0F : 8'(d + 1));
    end
    pm_mode = 3'h0;
    wr(8'h80, 8'h18);
    cmp({4'h0, dma_rate}, 8'h00);
    for (int o = 0; o < 2; o++) begin
      osc = 1'(o);
      wr(8'h82, 8'(8'h21 | ((1 - o) << 3)));
      rd(8'h82);
      cmp(rv, 8'(8'h21 | (o << 3)));
    end
    $display("test speeds done");
    pm_mode = 3'h3;
    wr(8'h82, 8'h31);
    cmp({7'h00, hi_pll}, 8'h00);
    wr(8'h82, 8'h21);
    cmp({7'h00, hi_pll}, 8'h01);
    for (int c = 0; c < 4; c += 3) begin
      wr(8'h82, 8'(8'h20 | (c << 1)));
      pm_mode = 3'h4;
      tick(4);
      cmp({7'h00, sys_pll}, 8'h00);
      pm_mode = 3'h0;
      tick(2);
      n = 0;
      while (sys_rdy !== 1'b1 && n < 100) begin
        tick(1);
        n++;
      end
      cmp(8'(n >= (32 >> c) - 3 && n <= (32 >> c) + 2), 8'h01);
    end
    wr(8'h82, 8'h21);
    pm_mode = 3'h4;
    tick(4);
    cmp({7'h00, sys_pll}, 8'h01);
    pm_mode = 3'h0;
    for (int i = 0; i < 16; i++) begin
      wr(8'h83, 8'(i));
      cmp({4'h0, pin_sel}, 8'(i));
      cmp({7'h00, pin_oe}, 8'(!i[3] && i != 1));
    end
    $display("test plls and pin done");
    // slowdown in high mode: fast 16.59, slow 8.29
    pm_mode = 3'h1;
    hyp_en = 1'b0;
    ext_pwr = 1'b1;
    wr(8'h80, 8'h02);
    wr(8'h81, 8'h3C);
    wr(8'h81, 8'h1C);
    tick(200);
    cmp({4'h0, cpu_rate}, 8'h04);
    wr(8'h81, 8'h3C);
    dur(4'h4);
    near(76);
    dur(4'h3);
    near(160);
    // hyper slowdown: fast 66, slow 16.59
    hyp_en = 1'b1;
    pm_mode = 3'h2;
    ext_pwr = 1'b0;
    wr(8'h80, 8'h02);
    // restart from idle so the fast hold is timed from its first cycle
    wr(8'h81, 8'h00);
    cmp({4'h0, cpu_rate}, 8'h06);
    wr(8'h81, 8'h10);
    dur(4'h6);
    near(76);
    cmp({4'h0, cpu_rate}, 8'h04);
    dur(4'h4);
    near(20);
    cmp({4'h0, cpu_rate}, 8'h06);
    $display("test slowdown done");
    stop_test();
  end
endmodule
bind ccpc_top ccpc_monitor #(.PLL_UNIT(PLL_UNIT)) i_ccpc_monitor (
  .clk(clk), .nrst(nrst), .io_rd(io_rd), .io_rdata(io_rdata), .power_manager_mode(power_manager_mode),
  .processor_clock_rate(processor_clock_rate), .dma_clock_rate(dma_clock_rate), .high_pll_on(high_pll_on),
  .system_pll_on(system_pll_on), .system_pll_ready(system_pll_ready), .clock_pin_select(clock_pin_select),
  .clock_pin_oe(clock_pin_oe));
